//--- rtl/cmt_pkg.sv
/*
  constants, types and shared decode functions of the mailbox transmit control block.
  assumes a 50 mhz system clock and a plain register port with 8-bit address, 16-bit data.
*/
package cmt_pkg;
	localparam int MBX_NUM   = 16;
	localparam int MBX_IDX_W = 4;
	localparam int ADDR_W    = 8;
	localparam int DATA_W    = 16;

	// address split: top bit selects mailbox area, then mailbox number, then byte index
	localparam int ADDR_MBX_SEL = 7;
	localparam int ADDR_MBX_MSB = 6;
	localparam int ADDR_MBX_LSB = 3;
	localparam int ADDR_BYTE_MSB = 2;
	localparam int ADDR_REG_MSB  = 6;

	localparam logic [6:0] REG_PENDING  = 7'h00;
	localparam logic [6:0] REG_CANCEL   = 7'h01;
	localparam logic [6:0] REG_REMOTE   = 7'h02;
	localparam logic [6:0] REG_IRQ_STAT = 7'h03;
	localparam logic [6:0] REG_IRQ_MASK = 7'h04;
	localparam logic [6:0] REG_CONTROL  = 7'h05;
	localparam logic [6:0] REG_STATUS   = 7'h06;

	localparam logic [2:0] MB_EXT_HIGH  = 3'h0;
	localparam logic [2:0] MB_LEN       = 3'h1;
	localparam logic [2:0] MB_RSV_TWO   = 3'h2;
	localparam logic [2:0] MB_RSV_THREE = 3'h3;
	localparam logic [2:0] MB_RSV_FOUR  = 3'h4;
	localparam logic [2:0] MB_BASE_LOW  = 3'h5;
	localparam logic [2:0] MB_BASE_HIGH = 3'h6;
	localparam logic [2:0] MB_EXT_LOW   = 3'h7;
	localparam int MB_BYTES = 8;

	localparam int LEN_CODE_W   = 4;
	localparam int LEN_LONG_BIT = 3;
	localparam logic [3:0] LEN_MAX = 4'h8;
	localparam int BASE_LOW_MSB = 7;
	localparam int BASE_LOW_LSB = 5;
	localparam int BASE_ID_W    = 11;
	localparam int EXT_ID_W     = 16;

	localparam int IRQ_TX_DONE   = 0;
	localparam int IRQ_TX_CANCEL = 1;
	localparam int IRQ_TX_ERROR  = 2;
	localparam int IRQ_REMOTE    = 3;
	localparam int IRQ_SPACING   = 4;
	localparam int IRQ_W         = 5;

	localparam int CTRL_HALT     = 0;
	localparam int STAT_BUS_OFF  = 0;
	localparam int STAT_BUSY     = 1;
	localparam int STAT_SOON     = 2;
	localparam int STAT_SEL_LSB  = 4;

	localparam int SPACING_US    = 50;
	localparam int CLK_MHZ       = 50;
	localparam int SPACING_CYC   = SPACING_US * CLK_MHZ;
	localparam int SPACING_W     = 12;

	typedef enum logic [1:0]
	{
		CMT_ENG_IDLE = 2'b00,
		CMT_ENG_SEND = 2'b01,
		CMT_ENG_HOLD = 2'b11
	} cmt_eng_state_t;

	function automatic logic [3:0] payload_bytes(input logic [3:0] code);
		payload_bytes = code[LEN_LONG_BIT] ? LEN_MAX : {1'b0, code[2:0]};
	endfunction

	function automatic logic [15:0] mbx_onehot(input logic [3:0] idx);
		mbx_onehot = 16'h0001 << idx;
	endfunction
endpackage

//--- rtl/cmt_tx_if.sv
/*
  link between the register side and the transmit engine.
  assumes both ends run on the same system clock.
*/
`timescale 1ns/1ps
interface cmt_tx_if;
	logic [15:0] pending;
	logic [15:0] cancel;
	logic        bus_off;
	logic        halt;
	logic        core_done;
	logic        core_error;
	logic        busy;
	logic [3:0]  sel;
	logic        start;
	logic        done;
	logic        fail;

	modport ctl (output pending, output cancel, output bus_off, output halt, output core_done,
		output core_error, input busy, input sel, input start, input done, input fail);
	modport eng (input pending, input cancel, input bus_off, input halt, input core_done,
		input core_error, output busy, output sel, output start, output done, output fail);
endinterface

//--- rtl/cmt_tx_engine.sv
/*
  transmit engine: picks the lowest pending mailbox, launches it, waits for the bus core.
  assumes asynchronous active-low reset already released through the top's synchroniser.
*/
`timescale 1ns/1ps
module cmt_tx_engine
(
	input  wire logic sys_clk,
	input  wire logic rst_sync_n,
	cmt_tx_if.eng     t
);
	cmt_pkg::cmt_eng_state_t state_reg;
	cmt_pkg::cmt_eng_state_t state_next;
	logic [3:0]              sel_reg;
	logic [3:0]              sel_next;
	logic                    start_reg;
	logic                    start_next;
	logic                    done_reg;
	logic                    done_next;
	logic                    fail_reg;
	logic                    fail_next;
	logic [3:0]              first_idx;
	logic                    sel_cancel;

	always_comb
	begin
		first_idx = '0;
		for (int i = cmt_pkg::MBX_NUM - 1; i >= 0; i--)
			if (t.pending[i])
				first_idx = 4'(i);
	end

	assign sel_cancel = t.cancel[sel_reg];

	always_comb
	begin
		state_next = state_reg;
		sel_next   = sel_reg;
		start_next = 1'b0;
		done_next  = 1'b0;
		fail_next  = 1'b0;
		case (state_reg)
			cmt_pkg::CMT_ENG_IDLE:
				if (!t.bus_off && |t.pending)
				begin
					sel_next   = first_idx;
					start_next = 1'b1;
					state_next = cmt_pkg::CMT_ENG_SEND;
				end
			cmt_pkg::CMT_ENG_SEND:
				if (t.bus_off)
					state_next = cmt_pkg::CMT_ENG_HOLD;
				else if (t.core_done)
				begin
					done_next  = 1'b1;
					state_next = cmt_pkg::CMT_ENG_IDLE;
				end
				else if (t.core_error && sel_cancel)
				begin
					fail_next  = 1'b1;
					state_next = cmt_pkg::CMT_ENG_IDLE;
				end
				else if (t.core_error)
					start_next = 1'b1;
			cmt_pkg::CMT_ENG_HOLD:
				if (!t.bus_off && sel_cancel)
				begin
					fail_next  = 1'b1;
					state_next = cmt_pkg::CMT_ENG_IDLE;
				end
				else if (!t.bus_off)
				begin
					start_next = 1'b1;
					state_next = cmt_pkg::CMT_ENG_SEND;
				end
			default:
				state_next = cmt_pkg::CMT_ENG_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			state_reg <= cmt_pkg::CMT_ENG_IDLE;
			sel_reg   <= '0;
			start_reg <= 1'b0;
			done_reg  <= 1'b0;
			fail_reg  <= 1'b0;
		end
		else if (t.halt)
		begin
			state_reg <= cmt_pkg::CMT_ENG_IDLE;
			sel_reg   <= '0;
			start_reg <= 1'b0;
			done_reg  <= 1'b0;
			fail_reg  <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			sel_reg   <= sel_next;
			start_reg <= start_next;
			done_reg  <= done_next;
			fail_reg  <= fail_next;
		end
	end

	assign t.busy  = (state_reg != cmt_pkg::CMT_ENG_IDLE);
	assign t.sel   = sel_reg;
	assign t.start = start_reg;
	assign t.done  = done_reg;
	assign t.fail  = fail_reg;
endmodule

//--- rtl/cmt_top.sv
/*
  mailbox control bytes, transmit request and cancel flags, remote flags and interrupts.
  assumes a bus core beside it that sends the latched frame and reports done or error.
*/
// Local design decisions: the placing of the registers and strobed register access.
// Functional notes
// - length codes 0..7 give that many bytes; top bit set gives eight bytes.
// - base identifier bits 10..3 in high byte, bits 2..0 in low byte bits 7..5.
// - extended identifier low 16 bits in two read/write bytes, undefined after reset.
// - cancel drops only mailboxes not on the bus; the sending one stays pending.
// - without cancel, transmission retries until done, then pending clears.
// - in bus-off the engine holds and cancels wait; afterwards one send or error-cancel.
// - halt bit set then cleared resets the controller and drops queued messages.
// - sixteen mailboxes; remote frame received sets that mailbox's remote flag.
`timescale 1ns/1ps
module cmt_top
(
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic [7:0]  bus_addr,
	input  wire logic [15:0] bus_wdata,
	input  wire logic        bus_wr,
	input  wire logic        bus_rd,
	output logic      [15:0] bus_rdata,
	output logic             irq,
	input  wire logic        bus_off,
	input  wire logic        rx_remote_valid,
	input  wire logic [3:0]  rx_remote_mbx,
	input  wire logic        core_done,
	input  wire logic        core_error,
	output logic             can_tx_start,
	output logic      [3:0]  can_tx_mbx,
	output logic      [10:0] can_tx_base_id,
	output logic      [15:0] can_tx_ext_id,
	output logic      [3:0]  can_tx_len
);
	logic [1:0]  rst_pipe_reg;
	logic        rst_sync_n;
	logic [7:0]  mbx_mem [cmt_pkg::MBX_NUM][cmt_pkg::MB_BYTES];
	logic [15:0] pending_reg;
	logic [15:0] pending_next;
	logic [15:0] cancel_reg;
	logic [15:0] cancel_next;
	logic [15:0] remote_reg;
	logic [15:0] remote_next;
	logic [4:0]  irq_stat_reg;
	logic [4:0]  irq_stat_next;
	logic [4:0]  irq_mask_reg;
	logic        halt_reg;
	logic [11:0] spacing_reg;
	logic [11:0] spacing_next;
	logic [15:0] rdata_reg;
	logic [15:0] rdata_next;
	logic        irq_reg;
	logic        tx_start_reg;
	logic [3:0]  tx_mbx_reg;
	logic [10:0] tx_base_reg;
	logic [15:0] tx_ext_reg;
	logic [3:0]  tx_len_reg;

	cmt_tx_if t ();

	// reset release
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			rst_pipe_reg <= 2'b00;
		else
			rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
	end
	assign rst_sync_n = rst_pipe_reg[1];

	// address decode
	wire         in_mbx    = bus_addr[cmt_pkg::ADDR_MBX_SEL];
	wire   [3:0] mbx_idx   = bus_addr[cmt_pkg::ADDR_MBX_MSB:cmt_pkg::ADDR_MBX_LSB];
	wire   [2:0] byte_idx  = bus_addr[cmt_pkg::ADDR_BYTE_MSB:0];
	wire   [6:0] reg_idx   = bus_addr[cmt_pkg::ADDR_REG_MSB:0];
	wire         reg_wr    = bus_wr && !in_mbx;
	wire         wr_pend   = reg_wr && (reg_idx == cmt_pkg::REG_PENDING) && !halt_reg;
	wire         wr_cancel = reg_wr && (reg_idx == cmt_pkg::REG_CANCEL) && !halt_reg;
	wire         wr_remote = reg_wr && (reg_idx == cmt_pkg::REG_REMOTE);
	wire         wr_istat  = reg_wr && (reg_idx == cmt_pkg::REG_IRQ_STAT);
	wire         wr_imask  = reg_wr && (reg_idx == cmt_pkg::REG_IRQ_MASK);
	wire         wr_ctrl   = reg_wr && (reg_idx == cmt_pkg::REG_CONTROL);
	wire         wr_mbx    = bus_wr && in_mbx && !halt_reg;

	// mailbox storage, no reset on purpose
	always_ff @(posedge sys_clk)
	begin
		if (wr_mbx)
			mbx_mem[mbx_idx][byte_idx] <= bus_wdata[7:0];
	end

	// cancel of mailboxes that are not on the bus
	logic [15:0] cancel_drop;
	genvar gi;
	generate
		for (gi = 0; gi < cmt_pkg::MBX_NUM; gi++)
		begin : g_drop
			assign cancel_drop[gi] = cancel_reg[gi] && !bus_off
				&& !(t.busy && (t.sel == 4'(gi)));
		end
	endgenerate

	wire  [15:0] sel_hot    = cmt_pkg::mbx_onehot(t.sel);
	wire  [15:0] end_clr    = (t.done || t.fail) ? sel_hot : 16'h0000;
	wire  [15:0] flag_clr   = cancel_drop | end_clr;
	wire  [15:0] pend_set   = wr_pend ? bus_wdata : 16'h0000;
	wire  [15:0] canc_set   = wr_cancel ? bus_wdata : 16'h0000;
	wire         ev_cancel  = |(cancel_drop & pending_reg);
	wire         req_write  = (wr_pend || wr_cancel) && (|bus_wdata);
	wire         soon       = (spacing_reg != 12'h000);
	wire  [15:0] remote_set = rx_remote_valid ? cmt_pkg::mbx_onehot(rx_remote_mbx) : 16'h0000;
	wire  [15:0] remote_clr = wr_remote ? bus_wdata : 16'h0000;
	wire   [4:0] stat_clr   = wr_istat ? bus_wdata[4:0] : 5'h00;

	logic [4:0] irq_ev;
	always_comb
	begin
		irq_ev = '0;
		irq_ev[cmt_pkg::IRQ_TX_DONE]   = t.done;
		irq_ev[cmt_pkg::IRQ_TX_CANCEL] = ev_cancel;
		irq_ev[cmt_pkg::IRQ_TX_ERROR]  = t.fail;
		irq_ev[cmt_pkg::IRQ_REMOTE]    = rx_remote_valid;
		irq_ev[cmt_pkg::IRQ_SPACING]   = req_write && soon;
	end

	// set wins over clear for every flag while halt is low; halt clears them all
	assign pending_next  = halt_reg ? 16'h0000 : ((pending_reg & ~flag_clr) | pend_set);
	assign cancel_next   = halt_reg ? 16'h0000 : ((cancel_reg & ~flag_clr) | canc_set);
	assign remote_next   = halt_reg ? 16'h0000 : ((remote_reg & ~remote_clr) | remote_set);
	assign irq_stat_next = halt_reg ? 5'h00 : ((irq_stat_reg & ~stat_clr) | irq_ev);
	assign spacing_next  = req_write ? 12'(cmt_pkg::SPACING_CYC) :
		(soon ? spacing_reg - 12'h001 : spacing_reg);

	always_ff @(posedge sys_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			pending_reg  <= '0;
			cancel_reg   <= '0;
			remote_reg   <= '0;
			irq_stat_reg <= '0;
			spacing_reg  <= '0;
		end
		else
		begin
			pending_reg  <= pending_next;
			cancel_reg   <= cancel_next;
			remote_reg   <= remote_next;
			irq_stat_reg <= irq_stat_next;
			spacing_reg  <= spacing_next;
		end
	end

	// control and mask survive halt so software can release it
	always_ff @(posedge sys_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			halt_reg     <= 1'b0;
			irq_mask_reg <= '0;
		end
		else
		begin
			if (wr_ctrl)
				halt_reg <= bus_wdata[cmt_pkg::CTRL_HALT];
			if (wr_imask)
				irq_mask_reg <= bus_wdata[4:0];
		end
	end

	assign t.pending    = pending_reg;
	assign t.cancel     = cancel_reg;
	assign t.bus_off    = bus_off;
	assign t.halt       = halt_reg;
	assign t.core_done  = core_done;
	assign t.core_error = core_error;

	cmt_tx_engine u_engine
	(
		.sys_clk    (sys_clk),
		.rst_sync_n (rst_sync_n),
		.t          (t.eng)
	);

	// frame fields of the launched mailbox
	wire  [7:0] sel_len   = mbx_mem[t.sel][cmt_pkg::MB_LEN];
	wire  [7:0] sel_bhigh = mbx_mem[t.sel][cmt_pkg::MB_BASE_HIGH];
	wire  [7:0] sel_blow  = mbx_mem[t.sel][cmt_pkg::MB_BASE_LOW];
	wire [10:0] sel_base  = {sel_bhigh, sel_blow[cmt_pkg::BASE_LOW_MSB:cmt_pkg::BASE_LOW_LSB]};
	wire [15:0] sel_ext   = {mbx_mem[t.sel][cmt_pkg::MB_EXT_HIGH], mbx_mem[t.sel][cmt_pkg::MB_EXT_LOW]};
	wire  [3:0] sel_bytes = cmt_pkg::payload_bytes(sel_len[cmt_pkg::LEN_CODE_W-1:0]);

	always_ff @(posedge sys_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			tx_start_reg <= 1'b0;
			tx_mbx_reg   <= '0;
			tx_base_reg  <= '0;
			tx_ext_reg   <= '0;
			tx_len_reg   <= '0;
		end
		else
		begin
			tx_start_reg <= t.start && !halt_reg;
			if (t.start && !halt_reg)
			begin
				tx_mbx_reg  <= t.sel;
				tx_base_reg <= sel_base;
				tx_ext_reg  <= sel_ext;
				tx_len_reg  <= sel_bytes;
			end
		end
	end

	// read path
	logic [15:0] status_word;
	always_comb
	begin
		status_word = '0;
		status_word[cmt_pkg::STAT_BUS_OFF] = bus_off;
		status_word[cmt_pkg::STAT_BUSY]    = t.busy;
		status_word[cmt_pkg::STAT_SOON]    = soon;
		status_word[cmt_pkg::STAT_SEL_LSB +: cmt_pkg::MBX_IDX_W] = t.sel;
	end

	wire [15:0] mbx_rd = {8'h00, mbx_mem[mbx_idx][byte_idx]};

	always_comb
	begin
		rdata_next = '0;
		if (bus_rd && in_mbx)
			rdata_next = mbx_rd;
		else if (bus_rd)
			case (reg_idx)
				cmt_pkg::REG_PENDING:  rdata_next = pending_reg;
				cmt_pkg::REG_CANCEL:   rdata_next = cancel_reg;
				cmt_pkg::REG_REMOTE:   rdata_next = remote_reg;
				cmt_pkg::REG_IRQ_STAT: rdata_next = {11'h000, irq_stat_reg};
				cmt_pkg::REG_IRQ_MASK: rdata_next = {11'h000, irq_mask_reg};
				cmt_pkg::REG_CONTROL:  rdata_next = {15'h0000, halt_reg};
				cmt_pkg::REG_STATUS:   rdata_next = status_word;
				default:               rdata_next = '0;
			endcase
	end

	always_ff @(posedge sys_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			rdata_reg <= '0;
			irq_reg   <= 1'b0;
		end
		else
		begin
			rdata_reg <= rdata_next;
			irq_reg   <= |(irq_stat_reg & irq_mask_reg);
		end
	end

	assign bus_rdata      = rdata_reg;
	assign irq            = irq_reg;
	assign can_tx_start   = tx_start_reg;
	assign can_tx_mbx     = tx_mbx_reg;
	assign can_tx_base_id = tx_base_reg;
	assign can_tx_ext_id  = tx_ext_reg;
	assign can_tx_len     = tx_len_reg;
endmodule

//--- verification/cmt_top_properties.sv
/*
  port-level checker for cmt_top, bound to every instance.
  assumes the far side answers each launch once, and no events arrive while halt is set.
*/
`timescale 1ns/1ps
module cmt_top_properties
(
	input wire logic        sys_clk,
	input wire logic        rst_n,
	input wire logic [7:0]  bus_addr,
	input wire logic [15:0] bus_wdata,
	input wire logic        bus_wr,
	input wire logic        bus_rd,
	input wire logic [15:0] bus_rdata,
	input wire logic        irq,
	input wire logic        bus_off,
	input wire logic        rx_remote_valid,
	input wire logic [3:0]  rx_remote_mbx,
	input wire logic        core_done,
	input wire logic        core_error,
	input wire logic        can_tx_start,
	input wire logic [3:0]  can_tx_mbx,
	input wire logic [10:0] can_tx_base_id,
	input wire logic [15:0] can_tx_ext_id,
	input wire logic [3:0]  can_tx_len
);
	logic [2:0] idle_cnt;
	logic       flight;
	logic       halt_q;
	logic [4:0] mask_q;
	wire logic  pend_wr = bus_wr && bus_addr == 8'h00 && bus_wdata != 16'h0000;

	// shadow copies of what software wrote, and how long the engine has been quiet
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			idle_cnt <= 3'h0;
			flight <= 1'b0;
			halt_q <= 1'b0;
			mask_q <= 5'h00;
		end
		else
		begin
			if (can_tx_start || core_done || core_error || bus_off)
				idle_cnt <= 3'h0;
			else if (idle_cnt != 3'h7)
				idle_cnt <= idle_cnt + 3'h1;
			if (can_tx_start)
				flight <= 1'b1;
			else if (core_done || core_error || bus_off)
				flight <= 1'b0;
			if (bus_wr && bus_addr == 8'h05)
				halt_q <= bus_wdata[0];
			if (bus_wr && bus_addr == 8'h04)
				mask_q <= bus_wdata[4:0];
		end
	end

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	sequence s_parked;
		bus_off [*3];
	endsequence
	sequence s_halted;
		halt_q [*3];
	endsequence

	a_rdata_idle: assert property (!$past(bus_rd) |-> bus_rdata == 16'h0000)
		else $error("read data not zero outside the read answer cycle");
	a_len_cap: assert property (can_tx_start |-> can_tx_len <= 4'h8)
		else $error("launched length above eight bytes");
	a_start_pulse: assert property (can_tx_start |=> !can_tx_start)
		else $error("launch pulse longer than one cycle");
	a_park_quiet: assert property (s_parked |-> !can_tx_start)
		else $error("launch while bus-off");
	a_one_flight: assert property (can_tx_start |-> !flight)
		else $error("second launch before the first was answered");
	a_fields_hold: assert property (!can_tx_start |-> $stable({can_tx_mbx, can_tx_base_id, can_tx_ext_id, can_tx_len}))
		else $error("frame fields changed without a launch");
	a_req_launch: assert property (pend_wr && idle_cnt == 3'h7 && !flight && !halt_q && !bus_off |-> ##3 can_tx_start)
		else $error("request on an idle engine not launched");
	a_remote_irq: assert property (rx_remote_valid && mask_q[3] && !halt_q |-> ##[1:3] irq)
		else $error("unmasked remote reception raised no interrupt");
	a_halt_quiet: assert property (s_halted |-> !irq && !can_tx_start)
		else $error("interrupt or launch while halted");
endmodule

bind cmt_top cmt_top_properties chk_u
(
	.sys_clk(sys_clk), .rst_n(rst_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
	.bus_rd(bus_rd), .bus_rdata(bus_rdata), .irq(irq), .bus_off(bus_off), .rx_remote_valid(rx_remote_valid),
	.rx_remote_mbx(rx_remote_mbx), .core_done(core_done), .core_error(core_error),
	.can_tx_start(can_tx_start), .can_tx_mbx(can_tx_mbx), .can_tx_base_id(can_tx_base_id),
	.can_tx_ext_id(can_tx_ext_id), .can_tx_len(can_tx_len)
);

//--- verification/cmt_can_node.sv
/*
  behavioural model of the remote nodes: answers each launch after a set delay, unless bus-off is high when the delay ends.
  assumes launch and bus-off come from the block under test's clock domain.
*/
`timescale 1ns/1ps
module cmt_can_node
(
	input  wire logic        sys_clk,
	input  wire logic        can_tx_start,
	input  wire logic        bus_off,
	input  wire logic        fail_req,
	input  wire logic [15:0] delay,
	output logic             core_done,
	output logic             core_error
);
	initial
	begin
		core_done = 1'b0;
		core_error = 1'b0;
		forever
		begin
			// mid-cycle look at the launch pulse keeps clear of the edge
			@(negedge sys_clk);
			if (can_tx_start === 1'b1)
			begin
				repeat (delay) @(posedge sys_clk);
				// a frame caught by bus-off is lost and never answered
				if (bus_off !== 1'b1)
				begin
					core_done <= !fail_req;
					core_error <= fail_req;
					@(posedge sys_clk);
					core_done <= 1'b0;
					core_error <= 1'b0;
				end
			end
		end
	end
endmodule

//--- verification/testbench.sv
/*
  self-checking bench for cmt_top: register tasks, launches, cancel, bus-off, halt.
  assumes cmt_can_node answers the launches and cmt_top_properties is bound.
*/
`timescale 1ns/1ps
module testbench;
	logic        sys_clk;
	logic        rst_n;
	logic [7:0]  bus_addr;
	logic [15:0] bus_wdata;
	logic        bus_wr;
	logic        bus_rd;
	logic [15:0] bus_rdata;
	logic        irq;
	logic        bus_off;
	logic        rx_remote_valid;
	logic [3:0]  rx_remote_mbx;
	logic        core_done;
	logic        core_error;
	logic        can_tx_start;
	logic [3:0]  can_tx_mbx;
	logic [10:0] can_tx_base_id;
	logic [15:0] can_tx_ext_id;
	logic [3:0]  can_tx_len;
	logic        fail_req;
	logic [15:0] delay;
	logic [15:0] v;
	logic [10:0] id;
	logic [15:0] ext;
	int          err_count;
	int          checked;
	int          i;

	cmt_top dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
		.bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .irq(irq), .bus_off(bus_off),
		.rx_remote_valid(rx_remote_valid), .rx_remote_mbx(rx_remote_mbx), .core_done(core_done),
		.core_error(core_error), .can_tx_start(can_tx_start), .can_tx_mbx(can_tx_mbx),
		.can_tx_base_id(can_tx_base_id), .can_tx_ext_id(can_tx_ext_id), .can_tx_len(can_tx_len));
	cmt_can_node node_u (.sys_clk(sys_clk), .can_tx_start(can_tx_start), .bus_off(bus_off),
		.fail_req(fail_req), .delay(delay), .core_done(core_done), .core_error(core_error));

	initial
	begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		checked++;
		if (g !== e)
		begin
			err_count++;
			$display("unexpected %s: expected %h, seen %h", n, e, g);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		bus_addr <= a;
		bus_wdata <= d;
		bus_wr <= 1'b1;
		@(posedge sys_clk);
		bus_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge sys_clk);
		bus_addr <= a;
		bus_rd <= 1'b1;
		@(posedge sys_clk);
		bus_rd <= 1'b0;
		#1 d = bus_rdata;
	endtask

	task automatic rchk(input string n, input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
		rd(a, v);
		chk(n, e, v & m);
	endtask

	// fills every byte of one mailbox, reserved ones included
	task automatic mbx(input logic [3:0] m, input logic [3:0] len);
		wr({1'b1, m, 3'h0}, {8'h00, ext[15:8]});
		wr({1'b1, m, 3'h1}, {12'h000, len});
		for (int b = 2; b < 5; b++)
			wr({1'b1, m, b[2:0]}, 16'h0000);
		wr({1'b1, m, 3'h5}, {8'h00, id[2:0], 5'h00});
		wr({1'b1, m, 3'h6}, {8'h00, id[10:3]});
		wr({1'b1, m, 3'h7}, {8'h00, ext[7:0]});
	endtask

	task automatic launch(input logic [3:0] m, input logic [3:0] bytes);
		@(posedge sys_clk);
		#1 i = 0;
		while (can_tx_start !== 1'b1 && i < 4000)
		begin
			@(posedge sys_clk);
			#1 i++;
		end
		chk("launch", 16'h0001, {15'h0000, can_tx_start});
		chk("mailbox", {12'h000, m}, {12'h000, can_tx_mbx});
		chk("length", {12'h000, bytes}, {12'h000, can_tx_len});
		chk("base id", {5'h00, id}, {5'h00, can_tx_base_id});
		chk("ext id", ext, can_tx_ext_id);
	endtask

	task report_and_stop;
		$display("comparisons %0d, mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial
	begin
		repeat (90000) @(posedge sys_clk);
		err_count++;
		report_and_stop;
	end

	initial
	begin
		rst_n = 1'b0;
		bus_addr = 8'h00;
		bus_wdata = 16'h0000;
		bus_wr = 1'b0;
		bus_rd = 1'b0;
		bus_off = 1'b0;
		rx_remote_valid = 1'b0;
		rx_remote_mbx = 4'h0;
		fail_req = 1'b0;
		delay = 16'h000a;
		err_count = 0;
		checked = 0;
		repeat (16) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge sys_clk);
		rchk("pending", 8'h00, 16'hffff, 16'h0000);
		rchk("cancel", 8'h01, 16'hffff, 16'h0000);
		rchk("unmapped", 8'h7f, 16'hffff, 16'h0000);
		wr(8'h04, 16'h001f);
		for (int c = 0; c < 16; c++)
		begin
			id = {c[3:0], 7'h2b} ^ 11'h555;
			ext = {c[3:0], 12'h5a3};
			mbx(c[3:0], c[3:0]);
			wr(8'h00, 16'h0001 << c);
			launch(c[3:0], c[3] ? 4'h8 : {1'b0, c[2:0]});
			repeat (20) @(posedge sys_clk);
			rchk("pending", 8'h00, 16'hffff, 16'h0000);
			rchk("irq status", 8'h03, 16'h001f, 16'h0001);
			chk("irq", 16'h0001, {15'h0000, irq});
			wr(8'h03, 16'h001f);
			repeat (2500) @(posedge sys_clk);
			chk("irq", 16'h0000, {15'h0000, irq});
		end
		// a failed frame goes out again without software help
		id = 11'h123;
		ext = 16'hbeef;
		mbx(4'h3, 4'h2);
		fail_req <= 1'b1;
		wr(8'h00, 16'h0008);
		launch(4'h3, 4'h2);
		// the first answer samples the failure request ten cycles after the launch
		repeat (12) @(posedge sys_clk);
		fail_req <= 1'b0;
		launch(4'h3, 4'h2);
		repeat (20) @(posedge sys_clk);
		rchk("pending", 8'h00, 16'hffff, 16'h0000);
		wr(8'h03, 16'h001f);
		repeat (2500) @(posedge sys_clk);
		delay <= 16'h0bb8;
		mbx(4'h1, 4'h8);
		mbx(4'h5, 4'h1);
		wr(8'h00, 16'h0022);
		launch(4'h1, 4'h8);
		repeat (2500) @(posedge sys_clk);
		wr(8'h01, 16'h0022);
		rchk("pending", 8'h00, 16'hffff, 16'h0002);
		rd(8'h01, v);
		i = 0;
		while (v !== 16'h0000 && i < 3000)
		begin
			wr(8'h01, 16'h0002);
			rd(8'h01, v);
			i++;
		end
		chk("cancel", 16'h0000, v);
		rchk("pending", 8'h00, 16'hffff, 16'h0000);
		rchk("irq status", 8'h03, 16'h0012, 16'h0012);
		wr(8'h03, 16'h001f);
		delay <= 16'h0014;
		repeat (2500) @(posedge sys_clk);
		mbx(4'h7, 4'h3);
		wr(8'h00, 16'h0080);
		launch(4'h7, 4'h3);
		@(posedge sys_clk) bus_off <= 1'b1;
		repeat (2500) @(posedge sys_clk);
		wr(8'h01, 16'h0080);
		rchk("cancel", 8'h01, 16'hffff, 16'h0080);
		rchk("pending", 8'h00, 16'hffff, 16'h0080);
		@(posedge sys_clk) bus_off <= 1'b0;
		repeat (20) @(posedge sys_clk);
		rchk("pending", 8'h00, 16'hffff, 16'h0000);
		rchk("cancel", 8'h01, 16'hffff, 16'h0000);
		rchk("irq status", 8'h03, 16'h0004, 16'h0004);
		wr(8'h03, 16'h001f);
		wr(8'h04, 16'h0000);
		@(posedge sys_clk);
		rx_remote_mbx <= 4'h9;
		rx_remote_valid <= 1'b1;
		@(posedge sys_clk);
		rx_remote_valid <= 1'b0;
		rchk("remote", 8'h02, 16'hffff, 16'h0200);
		chk("irq masked", 16'h0000, {15'h0000, irq});
		wr(8'h04, 16'h001f);
		rchk("irq status", 8'h03, 16'h0008, 16'h0008);
		chk("irq", 16'h0001, {15'h0000, irq});
		wr(8'h02, 16'h0200);
		wr(8'h03, 16'h001f);
		rchk("remote", 8'h02, 16'hffff, 16'h0000);
		chk("irq", 16'h0000, {15'h0000, irq});
		@(posedge sys_clk) rx_remote_valid <= 1'b1;
		@(posedge sys_clk) rx_remote_valid <= 1'b0;
		repeat (3) @(posedge sys_clk);
		chk("irq", 16'h0001, {15'h0000, irq});
		@(posedge sys_clk) bus_off <= 1'b1;
		repeat (2500) @(posedge sys_clk);
		wr(8'h00, 16'h0010);
		rchk("pending", 8'h00, 16'hffff, 16'h0010);
		wr(8'h05, 16'h0001);
		rchk("pending", 8'h00, 16'hffff, 16'h0000);
		wr(8'h05, 16'h0000);
		@(posedge sys_clk) bus_off <= 1'b0;
		repeat (20) @(posedge sys_clk);
		rchk("pending", 8'h00, 16'hffff, 16'h0000);
		report_and_stop;
	end
endmodule
